// ### verilog/opcrc_defines.svh
// constants for the panel command and reset control block
`ifndef OPCRC_DEFINES_SVH
`define OPCRC_DEFINES_SVH

// power-on values of the state held here
`define OPCRC_CONTRAST_RST      8'h7f
`define OPCRC_START_LINE_RST    6'h00
`define OPCRC_COLUMN_RST        8'h00
`define OPCRC_PUMP_RST          2'h2
`define OPCRC_CMD_POR_LOW       8'h00
`define OPCRC_CMD_POR_HIGH      8'h10
`define OPCRC_CMD_POR_PUMP      8'h32

// command encodings
`define OPCRC_OP_COL_LOW        4'h0
`define OPCRC_OP_COL_HIGH       4'h1
`define OPCRC_OP_PUMP           6'h0c

// edges after nrst before the pin synchroniser shows real pin levels
`define OPCRC_SYNC_SETTLE       3'h4

// host supply settle time, kept for reference by the far side
`define OPCRC_SUPPLY_WAIT_MS    100

`endif

// ### verilog/opcrc_pkg.sv
// types shared by the panel command and reset control block
package opcrc_pkg;

   // control state: held in init, or running
   typedef enum logic [0:0] {
      OPCRC_ST_INIT = 1'b0,
      OPCRC_ST_RUN  = 1'b1
   } opcrc_state_t;

   // decoded kind of a command byte
   typedef enum logic [1:0] {
      OPCRC_CMD_COL_LOW  = 2'h0,
      OPCRC_CMD_COL_HIGH = 2'h1,
      OPCRC_CMD_PUMP     = 2'h2,
      OPCRC_CMD_OTHER    = 2'h3
   } opcrc_cmd_t;

endpackage : opcrc_pkg

// ### verilog/opcrc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module opcrc_pin_sync (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // raw pins: init, chip select, data/command select
   input  wire logic [2:0] pin_raw,
   // filtered levels
   output logic      [2:0] pin_level
);

   logic [2:0] stage1;      // metastable catch, read by stage2 only
   logic [2:0] stage2;      // second stage
   logic [2:0] stage3;      // third stage
   logic [2:0] next_level;  // next filtered level

   // a change counts only once stages two and three agree
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_level[i];
      end
   end

   // idle value is all high: pins are inactive high
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stage1    <= 3'h7;
         stage2    <= 3'h7;
         stage3    <= 3'h7;
         pin_level <= 3'h7;
      end else begin
         stage1    <= pin_raw;
         stage2    <= stage1;
         stage3    <= stage2;
         pin_level <= next_level;
      end
   end

endmodule : opcrc_pin_sync
`default_nettype wire

// ### verilog/opcrc_top.sv
// command decode and reset state of the panel controller
`timescale 1ns/1ns
`default_nettype none
`include "opcrc_defines.svh"
module opcrc_top
   import opcrc_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // host pins
   input  wire logic       init_pin_n,
   input  wire logic       chip_sel_n,
   input  wire logic       cmd_data_flag,
   // byte from the serial or parallel front end, same clock
   input  wire logic       byte_valid,
   input  wire logic [7:0] byte_data,
   input  wire logic       two_wire_mode,
   input  wire logic       two_wire_is_data,
   // front end control
   output logic            serial_shift_clear,
   output logic            slave_addr_low_bit,
   // display state
   output logic            display_on,
   output logic            mode_12864,
   output logic            column_driver_remap,
   output logic            row_remap,
   output logic            scan_reverse,
   output logic            entire_display_on,
   output logic      [5:0] start_line,
   output logic      [7:0] contrast,
   output logic      [7:0] column_addr,
   output logic      [1:0] pump_voltage,
   // display data to the ram path
   output logic            data_valid,
   output logic      [7:0] data_byte,
   // commands handed to the other decoders
   output logic            cmd_pass_valid,
   output logic      [7:0] cmd_pass_byte
);

   logic [2:0]   pin_level;         // synchronised init, select, d/c
   logic         init_low;          // init pin held low
   logic         selected;          // chip select active
   logic         dc_level;          // synchronised d/c pin
   logic         byte_taken;        // byte accepted this cycle
   logic         byte_is_data;      // byte goes to display ram
   opcrc_cmd_t   cmd_kind;          // decoded command kind
   opcrc_state_t state;             // control state
   opcrc_state_t next_state;
   logic [2:0]   settle;            // edges counted since reset release
   logic [2:0]   next_settle;
   logic         settled;           // synchroniser holds real pin levels again
   // next values, computed in the combinational processes
   logic [7:0]   next_column_addr;
   logic [1:0]   next_pump_voltage;
   logic         next_data_valid;
   logic [7:0]   next_data_byte;
   logic         next_cmd_pass_valid;
   logic [7:0]   next_cmd_pass_byte;

   // the opcode fields overlap: 0000 and 0001 are checked on the upper
   // nibble, the pump code on the upper six bits; the nibble checks go
   // first so the priority is explicit rather than left to the encodings
   // classify a command byte by its opcode bits
   function automatic opcrc_cmd_t opcrc_decode(input logic [7:0] b);
      opcrc_cmd_t k;
      k = OPCRC_CMD_OTHER;
      if (b[7:4] == `OPCRC_OP_COL_LOW) begin
         k = OPCRC_CMD_COL_LOW;
      end else if (b[7:4] == `OPCRC_OP_COL_HIGH) begin
         k = OPCRC_CMD_COL_HIGH;
      end else if (b[7:2] == `OPCRC_OP_PUMP) begin
         k = OPCRC_CMD_PUMP;
      end
      return k;
   endfunction : opcrc_decode

   // pins come from outside the clock domain
   // all three pins share one synchroniser so their relative order is kept;
   // a byte is acted on in the cycle it arrives, with the pin levels crossed so far;
   // a pin change takes about four cycles to reach those levels
   opcrc_pin_sync u_sync (
      .clock     (clock),
      .nrst      (nrst),
      .pin_raw   ({init_pin_n, chip_sel_n, cmd_data_flag}),
      .pin_level (pin_level)
   );

   assign init_low = ~pin_level[2];
   assign selected = ~pin_level[1];
   assign dc_level = pin_level[0];

   // the synchroniser leaves reset showing idle-high pins; an init pin that
   // is really held low would not be seen for a few edges, and bytes must not
   // slip through in that gap, so the block waits for the stages to refill
   assign settled = (settle == `OPCRC_SYNC_SETTLE);

   // in two-wire mode the d/c pin is an address bit, the front end says data or command
   // the address bit is only driven in two-wire mode so the other bus
   // modes see a steady zero and cannot mistake it for a match
   assign slave_addr_low_bit = two_wire_mode & dc_level;
   assign byte_is_data = two_wire_mode ? two_wire_is_data : dc_level;
   // bytes are ignored while held in init or not selected
   // a refused byte is dropped silently; there is no busy flag back to
   // the host, so the host must respect the select and init levels
   assign byte_taken = byte_valid & selected & (state == OPCRC_ST_RUN);
   assign cmd_kind   = opcrc_decode(byte_data);

   // the front end drops partial bits while the init pin is low
   // it also covers the settle window after reset, when the state is init
   assign serial_shift_clear = init_low | (state == OPCRC_ST_INIT);

   // reset-image outputs tied to constants; other decoders own later changes
   // these settings only ever show their power-on image here, since the
   // commands that would move them are decoded outside this block; they
   // are kept as ports so the panel side sees one consistent init state
   assign display_on          = 1'b0;
   assign mode_12864          = 1'b1;
   assign column_driver_remap = 1'b0;
   assign row_remap           = 1'b0;
   assign scan_reverse        = 1'b0;
   assign entire_display_on   = 1'b0;
   assign start_line          = `OPCRC_START_LINE_RST;
   assign contrast            = `OPCRC_CONTRAST_RST;

   // init holds the block, release leaves it one cycle later
   // leaving init also waits for the synchroniser to settle after reset
   always_comb begin
      next_state  = state;
      next_settle = settle;
      // settle counter saturates; it only restarts with nrst
      if (!settled) begin
         next_settle = settle + 3'h1;
      end
      unique case (state)
         OPCRC_ST_INIT: begin
            // stay held until the pins are trusted and init is high
            if (settled && !init_low) begin
               next_state = OPCRC_ST_RUN;
            end
         end
         OPCRC_ST_RUN: begin
            // init low at any time returns the block to its held state
            if (init_low) begin
               next_state = OPCRC_ST_INIT;
            end
         end
      endcase
   end

   // command and data handling
   // init has priority over any byte in the same cycle, so a byte that races
   // the init pin is dropped rather than half applied; only one byte can be
   // taken per cycle, which the front end guarantees by its valid pulse
   always_comb begin
      next_column_addr    = column_addr;
      next_pump_voltage   = pump_voltage;
      next_data_valid     = 1'b0;
      next_data_byte      = data_byte;
      next_cmd_pass_valid = 1'b0;
      next_cmd_pass_byte  = cmd_pass_byte;
      if (init_low || state == OPCRC_ST_INIT) begin
         // power-on image: column 0, pump at its default step
         // pump default is the low bits of the power-on pump command
         next_column_addr  = `OPCRC_COLUMN_RST;
         next_pump_voltage = `OPCRC_PUMP_RST;
      end else if (byte_taken && byte_is_data) begin
         // data goes to the ram path; column counter steps with it
         // the counter wraps at 8 bits; the ram side ignores columns it lacks
         next_data_valid  = 1'b1;
         next_data_byte   = byte_data;
         next_column_addr = column_addr + 8'h01;
      end else if (byte_taken) begin
         unique case (cmd_kind)
            OPCRC_CMD_COL_LOW: begin
               // high nibble kept, so the two halves may come in either order
               next_column_addr = {column_addr[7:4], byte_data[3:0]};
            end
            OPCRC_CMD_COL_HIGH: begin
               next_column_addr = {byte_data[3:0], column_addr[3:0]};
            end
            OPCRC_CMD_PUMP: begin
               // only two bits are held; the upper code bits select the command
               next_pump_voltage = byte_data[1:0];
            end
            OPCRC_CMD_OTHER: begin
               // left for the remaining decoders, no local effect
               next_cmd_pass_valid = 1'b1;
               next_cmd_pass_byte  = byte_data;
            end
         endcase
      end
   end

   // registers
   // every state bit here is reset asynchronously to its power-on image so
   // that the panel outputs are defined before the first clock arrives
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state          <= OPCRC_ST_INIT;
         settle         <= 3'h0;
         column_addr    <= `OPCRC_COLUMN_RST;
         pump_voltage   <= `OPCRC_PUMP_RST;
         data_valid     <= 1'b0;
         data_byte      <= 8'h00;
         cmd_pass_valid <= 1'b0;
         cmd_pass_byte  <= 8'h00;
      end else begin
         state          <= next_state;
         settle         <= next_settle;
         column_addr    <= next_column_addr;
         pump_voltage   <= next_pump_voltage;
         data_valid     <= next_data_valid;
         data_byte      <= next_data_byte;
         cmd_pass_valid <= next_cmd_pass_valid;
         cmd_pass_byte  <= next_cmd_pass_byte;
      end
   end

endmodule : opcrc_top
`default_nettype wire

// ### tb/opcrc_monitor.sv
// port assertions for the panel command and reset control block
`timescale 1ns/1ns
`default_nettype none
module opcrc_monitor (
   // clock and reset
   input wire logic       clock,
   input wire logic       nrst,
   // host pins and byte
   input wire logic       init_pin_n,
   input wire logic       chip_sel_n,
   input wire logic       cmd_data_flag,
   input wire logic       byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic       two_wire_mode,
   // outputs watched
   input wire logic       serial_shift_clear,
   input wire logic       slave_addr_low_bit,
   input wire logic       display_on,
   input wire logic       mode_12864,
   input wire logic       column_driver_remap,
   input wire logic       row_remap,
   input wire logic       scan_reverse,
   input wire logic       entire_display_on,
   input wire logic [5:0] start_line,
   input wire logic [7:0] contrast,
   input wire logic [7:0] column_addr,
   input wire logic [1:0] pump_voltage,
   input wire logic       data_valid,
   input wire logic [7:0] data_byte,
   input wire logic       cmd_pass_valid,
   input wire logic [7:0] cmd_pass_byte
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // seven samples cover the pin synchroniser latency
   sequence init_held; !init_pin_n[*7]; endsequence
   sequence cmd_sel; (init_pin_n && !chip_sel_n && !cmd_data_flag && !two_wire_mode)[*6]; endsequence
   sequence dat_sel; (init_pin_n && !chip_sel_n && cmd_data_flag && !two_wire_mode)[*6]; endsequence
   a_init_view: assert property (init_held |-> !display_on && mode_12864 && !entire_display_on
      && !column_driver_remap && !row_remap && !scan_reverse && start_line == 6'h00)
      else $error("init image wrong");
   a_init_regs: assert property (init_held |-> column_addr == 8'h00 && contrast == 8'h7f
      && pump_voltage == 2'h2 && serial_shift_clear) else $error("init registers wrong");
   a_col_low: assert property (cmd_sel ##0 (byte_valid && byte_data[7:4] == 4'h0)
      |=> column_addr[3:0] == $past(byte_data[3:0])) else $error("low nibble not loaded");
   a_col_high: assert property (cmd_sel ##0 (byte_valid && byte_data[7:4] == 4'h1)
      |=> column_addr[7:4] == $past(byte_data[3:0])) else $error("high nibble not loaded");
   a_pump_set: assert property (cmd_sel ##0 (byte_valid && byte_data[7:2] == 6'h0c)
      |=> pump_voltage == $past(byte_data[1:0])) else $error("pump not loaded");
   a_data_take: assert property (dat_sel ##0 byte_valid |=> data_valid && !cmd_pass_valid
      && data_byte == $past(byte_data) && column_addr == $past(column_addr) + 8'h01)
      else $error("data byte not taken");
   a_cmd_pass: assert property (cmd_sel ##0 (byte_valid && byte_data[7:5] != 3'h0
      && byte_data[7:2] != 6'h0c) |=> cmd_pass_valid && cmd_pass_byte == $past(byte_data)
      && $stable(column_addr) && $stable(pump_voltage)) else $error("command not passed");
   a_no_select: assert property (chip_sel_n[*6] |=> !data_valid && !cmd_pass_valid)
      else $error("byte taken while deselected");
   a_addr_bit: assert property ((two_wire_mode && cmd_data_flag)[*6] |-> slave_addr_low_bit)
      else $error("address bit missing");
endmodule : opcrc_monitor
bind opcrc_top opcrc_monitor u_mon (.*);
`default_nettype wire

// ### tb/opcrc_host.sv
// host model: drives the pins and hands over one byte per call
`timescale 1ns/1ns
`default_nettype none
module opcrc_host (
   // clock
   input  wire logic       clock,
   // pins and byte
   output logic            init_pin_n    = 1'b1,
   output logic            chip_sel_n    = 1'b1,
   output logic            cmd_data_flag = 1'b0,
   output logic            byte_valid    = 1'b0,
   output logic      [7:0] byte_data     = 8'h00
);
   // pins settle seven edges before the byte, since they are synchronised
   task put(input logic i_n, input logic s_n, input logic dc, input logic [7:0] b);
      @(posedge clock) #1;
      init_pin_n = i_n;
      chip_sel_n = s_n;
      cmd_data_flag = dc;
      repeat (7) @(posedge clock);
      #1 byte_valid = 1'b1;
      byte_data = b;
      // bus shows the inverse once released, not the old byte
      @(posedge clock) #1 byte_valid = 1'b0;
      byte_data = ~b;
   endtask : put
endmodule : opcrc_host
`default_nettype wire

// ### tb/tb_opcrc_top.sv
// self-checking bench for the panel command and reset control block
`timescale 1ns/1ns
`default_nettype none
module tb_opcrc_top;
   logic       clock = 1'b0, nrst = 1'b0, two_wire_mode = 1'b0, two_wire_is_data = 1'b0;
   logic       init_pin_n, chip_sel_n, cmd_data_flag, byte_valid, serial_shift_clear;
   logic       slave_addr_low_bit, display_on, mode_12864, column_driver_remap, row_remap;
   logic       scan_reverse, entire_display_on, data_valid, cmd_pass_valid;
   logic [1:0] pump_voltage;
   logic [5:0] start_line;
   logic [7:0] byte_data, contrast, column_addr, data_byte, cmd_pass_byte;
   logic [31:0] r;
   int         err_total = 0, comparisons = 0, col = 0, pump = 2;
   // setup order: display off first, display on once configured
   logic [8:0] cmds [13] = '{9'h0ae, 9'h00a, 9'h01f, 9'h030, 9'h031, 9'h032, 9'h033,
                             9'h02f, 9'h034, 9'h0af, 9'h00f, 9'h155, 9'h155};
   // 100 mhz clock
   always #5 clock = ~clock;
   opcrc_host host (.*);
   opcrc_top dut (.*);
   // one comparison, reported at once
   task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task close_out;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // one byte through the host, reference model updated, ports compared
   task step(input logic i_n, input logic s_n, input logic dc, input logic [7:0] b);
      logic tk, cp, ed;
      tk = i_n & ~s_n;
      ed = two_wire_mode ? two_wire_is_data : dc;
      cp = 1'b0;
      host.put(i_n, s_n, dc, b);
      if (!i_n) begin
         col = 0;
         pump = 2;
         check("image", {display_on, mode_12864, column_driver_remap, row_remap,
                scan_reverse, entire_display_on, 2'b00}, 8'h40);
         check("start", {2'b00, start_line}, 8'h00);
         check("contrast", contrast, 8'h7f);
      end
      else if (tk & ed) col = (col + 1) % 256;
      else if (tk & b[7:4] == 4'h0) col = (col & 8'hf0) | b[3:0];
      else if (tk & b[7:4] == 4'h1) col = (col & 8'h0f) | (b[3:0] << 4);
      else if (tk & b[7:2] == 6'h0c) pump = b[1:0];
      else cp = tk & ~ed;
      check("column", column_addr, col[7:0]);
      check("pump", pump_voltage, pump[1:0]);
      check("data_valid", data_valid, tk & ed);
      check("cmd_pass", cmd_pass_valid, cp);
      if (tk & ed) check("data_byte", data_byte, b);
      if (cp) check("pass_byte", cmd_pass_byte, b);
      check("shift_clear", serial_shift_clear, !i_n);
      check("addr_bit", slave_addr_low_bit, two_wire_mode & dc);
   endtask : step
   // main sequence: codes, wrap, address bit, then random traffic
   initial begin
      void'($urandom(32'h5429));
      repeat (16) @(posedge clock);
      #1 nrst = 1'b1;
      foreach (cmds[i]) step(1'b1, 1'b0, cmds[i][8], cmds[i][7:0]);
      step(1'b0, 1'b0, 1'b0, 8'h13);
      two_wire_mode = 1'b1;
      for (int d = 0; d < 2; d++) begin
         step(1'b1, 1'b1, d[0], 8'h00);
         check("addr_bit", slave_addr_low_bit, d[0]);
      end
      two_wire_mode = 1'b0;
      repeat (40) begin
         r = $urandom;
         two_wire_is_data = r[15];
         two_wire_mode = r[16];
         step(r[10:8] != 3'h0, r[13:11] == 3'h0, r[14], r[7:0]);
      end
      close_out();
   end
   // watchdog: the run needs about 5 us
   initial begin
      #50000;
      err_total++;
      close_out();
   end
endmodule : tb_opcrc_top
`default_nettype wire
